// File: cfg_status_cfg.svh
// Constants for the configuration status word and legacy serial output.
// Assumes inclusion by the package and the status block; definitions only.
`ifndef CFG_STATUS_CFG_SVH
`define CFG_STATUS_CFG_SVH

// Register select codes on the configuration port
`define STATUS_ADDR 5'h07
`define LEGACY_OUT_ADDR 5'h08
`define ADDR_W 5

// Status field positions
`define BIT_KEY_ORDER 15
`define BIT_DECRYPT 14
`define BIT_PART_ID 13
`define BIT_DONE 12
`define BIT_INIT 11
`define BIT_MODE_HI 10
`define BIT_MODE_LO 8
`define BIT_HOLD 7
`define BIT_GWE 6
`define BIT_TRISTATE 5
`define BIT_OVERRUN 4
`define BIT_MATCH 3
`define BIT_LOCK 2
`define BIT_SECURED 1
`define BIT_CRC 0

// Reset values
`define STATUS_RESET 32'h0000_0000
`define LEGACY_RESET 32'h0000_0000

// Serial mode codes of mode_select_pins
`define MODE_MASTER_SERIAL 3'h0
`define MODE_SLAVE_SERIAL 3'h7

// Legacy shifter bit count
`define LEGACY_BITS 32

`endif

// File: cfg_status_pkg.sv
// Types for the configuration status block.
// Assumes cfg_status_cfg.svh is on the include path.
`include "cfg_status_cfg.svh"
package cfg_status_pkg;
    // Access on the configuration port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } port_req_type;

    // Event strobes from the configuration engine
    typedef struct packed {
        logic key_out_of_order;
        logic frame_data_input_outside_decrypt;
        logic frame_data_input_without_id;
        logic data_too_fast;
        logic crc_fail;
        logic crc_pass;
    } cfg_event_type;

    // Legacy shifter states
    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_SHIFT = 2'b10
    } shift_state_type;
endpackage : cfg_status_pkg

// File: legacy_serial_out.sv
// Legacy output shifter: serialises a written word onto the daisy-chain output.
// Assumes the loader only asserts i_load in a serial configuration mode.
`timescale 1ns/10ps
`include "cfg_status_cfg.svh"
module legacy_serial_out
    import cfg_status_pkg::*;
#(
    parameter int BITS = `LEGACY_BITS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Load side
    input wire logic i_load,
    input wire logic [BITS-1:0] i_word,
    // Serial side
    output logic o_dout,
    output logic o_busy
);
    localparam int CW = $clog2(BITS + 1);
    shift_state_type state_reg;
    logic [BITS-1:0] shift_reg;
    logic [CW-1:0] count_reg;

    // State and bit counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= SH_IDLE;
            count_reg <= '0;
        end else begin
            unique case (state_reg)
                SH_IDLE: begin
                    if (i_load) begin
                        state_reg <= SH_SHIFT;
                        count_reg <= CW'(BITS);
                    end
                end
                SH_SHIFT: begin
                    count_reg <= count_reg - 1'b1;
                    if (count_reg == CW'(1)) begin
                        state_reg <= SH_IDLE;
                    end
                end
            endcase
        end
    end

    // Data shifter, MSB first
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg <= '0;
            o_dout <= 1'b0;
        end else if (state_reg == SH_IDLE && i_load) begin
            shift_reg <= i_word;
        end else if (state_reg == SH_SHIFT) begin
            o_dout <= shift_reg[BITS-1];
            shift_reg <= {shift_reg[BITS-2:0], 1'b0};
        end
    end

    // Busy flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_reg == SH_IDLE) ? i_load : (count_reg != CW'(1));
        end
    end
endmodule : legacy_serial_out

// File: config_status_reporting.sv
// Configuration status word and legacy serial output register.
// Assumes one config_clock domain; pins arrive asynchronously.
`timescale 1ns/10ps
`include "cfg_status_cfg.svh"
module config_status_reporting
    import cfg_status_pkg::*;
#(
    parameter int BANKS = 8,
    parameter int CLOCK_MANAGERS = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Parallel configuration port
    input wire port_req_type i_par_req,
    output logic [31:0] o_par_rdata,
    output logic o_par_rvalid,
    // Boundary-scan port
    input wire port_req_type i_jtag_req,
    output logic [31:0] o_jtag_rdata,
    output logic o_jtag_rvalid,
    // Configuration engine events and global signals
    input wire cfg_event_type i_event,
    input wire logic i_interconnect_hold_n,
    input wire logic i_global_write_en,
    input wire logic i_config_tristate_n,
    input wire logic i_decryptor_secured,
    // Per-bank and per-manager aggregates
    input wire logic [BANKS-1:0] i_bank_match,
    input wire logic [BANKS-1:0] i_bank_has_impedance_control,
    input wire logic [CLOCK_MANAGERS-1:0] i_clock_manager_lock,
    input wire logic [CLOCK_MANAGERS-1:0] i_clock_manager_used,
    // Device pins
    input wire logic i_program_pin_n,
    input wire logic i_done_pin,
    input wire logic i_init_pin,
    input wire logic [2:0] i_mode_select_pins,
    // Serial daisy-chain output
    output logic o_dout,
    output logic o_legacy_busy
);
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] program_pin_n_sync_reg;
    logic [1:0] done_sync_reg;
    logic [1:0] init_sync_reg;
    logic [2:0] mode_sync1_reg;
    logic [2:0] mode_sync2_reg;
    logic key_order_error_reg;
    logic decryptor_fault_reg;
    logic part_id_mismatch_reg;
    logic overrun_reg;
    logic crc_error_reg;
    logic [BANKS-1:0] bank_ok;
    logic [CLOCK_MANAGERS-1:0] cm_ok;
    logic impedance_matched_all;
    logic clock_managers_locked;
    logic [31:0] status_word;
    logic serial_mode;
    logic legacy_load;
    logic shifter_dout;
    logic shifter_busy;

    // Reset release through two flip-flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_pin_n_sync_reg <= 2'h3;
            done_sync_reg <= 2'h0;
            init_sync_reg <= 2'h0;
            mode_sync1_reg <= 3'h0;
            mode_sync2_reg <= 3'h0;
        end else begin
            program_pin_n_sync_reg <= {program_pin_n_sync_reg[0], i_program_pin_n};
            done_sync_reg <= {done_sync_reg[0], i_done_pin};
            init_sync_reg <= {init_sync_reg[0], i_init_pin};
            mode_sync1_reg <= i_mode_select_pins;
            mode_sync2_reg <= mode_sync1_reg;
        end
    end

    // Key order flag: set on a misordered key, held until program pin
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_order_error_reg <= 1'b0;
        end else if (i_event.key_out_of_order) begin
            key_order_error_reg <= 1'b1;
        end else if (!program_pin_n_sync_reg[1]) begin
            key_order_error_reg <= 1'b0;
        end
    end

    // Decryptor fault: sticky, set beats program clear
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            decryptor_fault_reg <= 1'b0;
        end else if (i_event.frame_data_input_outside_decrypt) begin
            decryptor_fault_reg <= 1'b1;
        end else if (!program_pin_n_sync_reg[1]) begin
            decryptor_fault_reg <= 1'b0;
        end
    end

    // Part ID mismatch: sticky until program pin
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            part_id_mismatch_reg <= 1'b0;
        end else if (i_event.frame_data_input_without_id) begin
            part_id_mismatch_reg <= 1'b1;
        end else if (!program_pin_n_sync_reg[1]) begin
            part_id_mismatch_reg <= 1'b0;
        end
    end

    // Input overrun flag
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_reg <= 1'b0;
        end else if (i_event.data_too_fast) begin
            overrun_reg <= 1'b1;
        end else if (!program_pin_n_sync_reg[1]) begin
            overrun_reg <= 1'b0;
        end
    end

    // CRC result: fail sets, a passing check or program pin clears
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_error_reg <= 1'b0;
        end else if (i_event.crc_fail) begin
            crc_error_reg <= 1'b1;
        end else if (i_event.crc_pass || !program_pin_n_sync_reg[1]) begin
            crc_error_reg <= 1'b0;
        end
    end

    // Per-bank and per-manager contributions
    genvar gb;
    generate
        for (gb = 0; gb < BANKS; gb++) begin : g_bank
            assign bank_ok[gb] = i_bank_match[gb] | ~i_bank_has_impedance_control[gb];
        end
        for (gb = 0; gb < CLOCK_MANAGERS; gb++) begin : g_cm
            assign cm_ok[gb] = i_clock_manager_lock[gb] | ~i_clock_manager_used[gb];
        end
    endgenerate
    assign impedance_matched_all = &bank_ok;
    assign clock_managers_locked = &cm_ok;

    // Status word assembly; upper half tied to zero
    always_comb begin
        status_word = `STATUS_RESET;
        status_word[`BIT_KEY_ORDER] = key_order_error_reg;
        status_word[`BIT_DECRYPT] = decryptor_fault_reg;
        status_word[`BIT_PART_ID] = part_id_mismatch_reg;
        status_word[`BIT_DONE] = done_sync_reg[1];
        status_word[`BIT_INIT] = init_sync_reg[1];
        status_word[`BIT_MODE_HI:`BIT_MODE_LO] = mode_sync2_reg;
        status_word[`BIT_HOLD] = i_interconnect_hold_n;
        status_word[`BIT_GWE] = i_global_write_en;
        status_word[`BIT_TRISTATE] = i_config_tristate_n;
        status_word[`BIT_OVERRUN] = overrun_reg;
        status_word[`BIT_MATCH] = impedance_matched_all;
        status_word[`BIT_LOCK] = clock_managers_locked;
        status_word[`BIT_SECURED] = i_decryptor_secured;
        status_word[`BIT_CRC] = crc_error_reg;
    end

    // Parallel port read answer, one cycle after the request
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_par_rdata <= 32'h0000_0000;
            o_par_rvalid <= 1'b0;
        end else begin
            o_par_rvalid <= i_par_req.rd;
            if (i_par_req.rd && i_par_req.addr == `STATUS_ADDR) begin
                o_par_rdata <= status_word;
            end else begin
                o_par_rdata <= 32'h0000_0000;
            end
        end
    end

    // Boundary-scan read answer, one cycle after the request
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_jtag_rdata <= 32'h0000_0000;
            o_jtag_rvalid <= 1'b0;
        end else begin
            o_jtag_rvalid <= i_jtag_req.rd;
            if (i_jtag_req.rd && i_jtag_req.addr == `STATUS_ADDR) begin
                o_jtag_rdata <= status_word;
            end else begin
                o_jtag_rdata <= 32'h0000_0000;
            end
        end
    end

    // Legacy output writes accepted only in serial modes from the parallel path
    // (serial bitstream arrives on that path); scan writes never load it
    assign serial_mode = (mode_sync2_reg == `MODE_MASTER_SERIAL) ||
                         (mode_sync2_reg == `MODE_SLAVE_SERIAL);
    assign legacy_load = i_par_req.wr && (i_par_req.addr == `LEGACY_OUT_ADDR) &&
                         serial_mode && !shifter_busy;

    // Serialiser for the daisy chain
    legacy_serial_out #(
        .BITS(`LEGACY_BITS)
    ) u_legacy (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_load(legacy_load),
        .i_word(i_par_req.wdata),
        .o_dout(shifter_dout),
        .o_busy(shifter_busy)
    );

    // Output flops for the serial pin
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_dout <= 1'b0;
            o_legacy_busy <= 1'b0;
        end else begin
            o_dout <= shifter_dout;
            o_legacy_busy <= shifter_busy;
        end
    end
endmodule : config_status_reporting

// File: cfg_host_model.sv
// Host model: issues one-cycle requests on the parallel or boundary-scan port.
// Assumes the bench calls xfer and samples answers at the returning falling edge.
`timescale 1ns/10ps
`include "cfg_status_cfg.svh"
module cfg_host_model
    import cfg_status_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Requests
    output port_req_type o_par_req,
    output port_req_type o_jtag_req
);
    // Idle ports at time zero
    initial begin
        o_par_req = '0;
        o_jtag_req = '0;
    end

    // Request held for one rising edge; released address and data show inverted values, rd and wr drop to zero
    task automatic xfer(input logic jt, input logic wr, input logic [`ADDR_W-1:0] a,
                        input logic [31:0] d);
        port_req_type r;
        port_req_type idle;
        r = {!wr, wr, a, d};
        idle = {2'b00, ~a, ~d};
        @(negedge i_clk);
        o_par_req = jt ? idle : r;
        o_jtag_req = jt ? r : idle;
        @(negedge i_clk);
        o_par_req = idle;
        o_jtag_req = idle;
    endtask : xfer
endmodule : cfg_host_model

// File: status_checker_asserts.sv
// Checker: read answers, live status bits, pin bits and legacy start.
// Assumes binding into config_status_reporting; sees only its ports.
`timescale 1ns/10ps
`include "cfg_status_cfg.svh"
module status_checker
    import cfg_status_pkg::*;
#(
    parameter int BANKS = 8,
    parameter int CLOCK_MANAGERS = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Ports
    input wire port_req_type i_par_req,
    input wire logic [31:0] o_par_rdata,
    input wire logic o_par_rvalid,
    input wire port_req_type i_jtag_req,
    input wire logic o_jtag_rvalid,
    input wire logic o_legacy_busy,
    // Status sources
    input wire logic i_interconnect_hold_n,
    input wire logic i_global_write_en,
    input wire logic i_config_tristate_n,
    input wire logic i_decryptor_secured,
    input wire logic [BANKS-1:0] i_bank_match,
    input wire logic [BANKS-1:0] i_bank_has_impedance_control,
    input wire logic [CLOCK_MANAGERS-1:0] i_clock_manager_lock,
    input wire logic [CLOCK_MANAGERS-1:0] i_clock_manager_used,
    input wire logic i_done_pin,
    input wire logic i_init_pin,
    input wire logic [2:0] i_mode_select_pins
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Helper terms
    logic st_rd;
    logic match_all;
    logic lock_all;
    logic [3:0] live;
    logic [4:0] pins;
    assign st_rd = i_par_req.rd && i_par_req.addr == `STATUS_ADDR;
    assign match_all = &(i_bank_match | ~i_bank_has_impedance_control);
    assign lock_all = &(i_clock_manager_lock | ~i_clock_manager_used);
    assign live = {i_interconnect_hold_n, i_global_write_en, i_config_tristate_n,
                   i_decryptor_secured};
    assign pins = {i_done_pin, i_init_pin, i_mode_select_pins};

    par_answer_a: assert property (
        i_par_req.rd |=> o_par_rvalid && o_par_rdata[31:16] == 16'h0000)
        else $error("parallel read answer wrong");
    jtag_answer_a: assert property (
        i_jtag_req.rd |=> o_jtag_rvalid)
        else $error("scan read answer missing");
    unmapped_zero_a: assert property (
        i_par_req.rd && !st_rd |=> o_par_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    live_bits_a: assert property (
        st_rd |=> {o_par_rdata[7:5], o_par_rdata[1]} == $past(live))
        else $error("live status bits wrong");
    match_and_a: assert property (
        st_rd |=> o_par_rdata[3] == $past(match_all))
        else $error("impedance match bit wrong");
    lock_and_a: assert property (
        st_rd |=> o_par_rdata[2] == $past(lock_all))
        else $error("lock bit wrong");
    pins_seen_a: assert property (
        $stable(pins)[*3] ##0 st_rd |=> o_par_rdata[12:8] == $past(pins))
        else $error("pin bits wrong");
    legacy_start_a: assert property (
        $rose(o_legacy_busy) |-> $past(i_par_req.wr, 2)
            && $past(i_par_req.addr, 2) == `LEGACY_OUT_ADDR)
        else $error("shift started without legacy write");
endmodule : status_checker

bind config_status_reporting status_checker #(.BANKS(BANKS),
    .CLOCK_MANAGERS(CLOCK_MANAGERS)) chk (.i_clk, .i_resetn, .i_par_req, .o_par_rdata,
    .o_par_rvalid, .i_jtag_req, .o_jtag_rvalid, .o_legacy_busy, .i_interconnect_hold_n,
    .i_global_write_en, .i_config_tristate_n, .i_decryptor_secured, .i_bank_match,
    .i_bank_has_impedance_control, .i_clock_manager_lock, .i_clock_manager_used,
    .i_done_pin, .i_init_pin, .i_mode_select_pins);

// File: tb_config_status_reporting.sv
// Testbench: random status sources and events, reads on both ports, legacy shifts.
// Assumes cfg_host_model and the bound checker; inputs change at falling edges.
`timescale 1ns/10ps
`include "cfg_status_cfg.svh"
module tb_config_status_reporting
    import cfg_status_pkg::*;
    ;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    port_req_type par_req;
    port_req_type jtag_req;
    logic [31:0] par_rdata;
    logic [31:0] jtag_rdata;
    logic par_rvalid, jtag_rvalid, dout, busy;
    cfg_event_type ev = '0;
    logic hold_n = 1'b1, global_write_en = 1'b0, tri_n = 1'b0, sec = 1'b0;
    logic program_pin_n_n = 1'b1, done = 1'b0, init = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [7:0] bm = 8'h00, bh = 8'h00;
    logic [3:0] lk = 4'h0, us = 4'h0;
    logic [4:0] flags = 5'h00;
    int errors = 0;
    int checks_done = 0;
    integer seed = 32'hE346;

    // Clock
    always #12.5 i_clk = ~i_clk;

    cfg_host_model hst (.i_clk, .o_par_req(par_req), .o_jtag_req(jtag_req));
    config_status_reporting dut (.i_clk, .i_resetn, .i_par_req(par_req),
        .o_par_rdata(par_rdata), .o_par_rvalid(par_rvalid), .i_jtag_req(jtag_req),
        .o_jtag_rdata(jtag_rdata), .o_jtag_rvalid(jtag_rvalid), .i_event(ev),
        .i_interconnect_hold_n(hold_n), .i_global_write_en(global_write_en),
        .i_config_tristate_n(tri_n), .i_decryptor_secured(sec), .i_bank_match(bm),
        .i_bank_has_impedance_control(bh), .i_clock_manager_lock(lk),
        .i_clock_manager_used(us), .i_program_pin_n(program_pin_n_n), .i_done_pin(done),
        .i_init_pin(init), .i_mode_select_pins(mode), .o_dout(dout), .o_legacy_busy(busy));

    task automatic print_verdict();
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : check

    // Expected word; flags hold bits 15,14,13,4,0
    function automatic logic [31:0] exp_status();
        return {16'h0000, flags[4:2], done, init, mode, hold_n, global_write_en, tri_n, flags[1],
                &(bm | ~bh), &(lk | ~us), sec, flags[0]};
    endfunction : exp_status

    task automatic rd_chk(input logic jt, input logic [`ADDR_W-1:0] a);
        logic [31:0] e;
        e = (a == `STATUS_ADDR) ? exp_status() : 32'h0000_0000;
        hst.xfer(jt, 1'b0, a, 32'h0000_0000);
        check({31'h0, jt ? jtag_rvalid : par_rvalid}, 32'h1, "no read answer");
        check(jt ? jtag_rdata : par_rdata, e, "status word");
    endtask : rd_chk

    // Random sources and events, optional program pulse, ignored write, reads
    task automatic rand_step();
        logic [31:0] r;
        logic [31:0] s;
        r = $random(seed);
        s = $random(seed);
        @(negedge i_clk);
        {hold_n, global_write_en, tri_n, sec, done, init, mode} = r[8:0];
        {bm, bh, lk, us} = s[23:0];
        ev = r[14:9] & r[20:15];
        flags[4:1] = flags[4:1] | ev[5:2];
        flags[0] = ev[1] | (flags[0] & ~ev[0]);
        @(negedge i_clk);
        ev = '0;
        if (r[23:21] == 3'h0) begin
            program_pin_n_n = 1'b0;
            repeat (4) @(negedge i_clk);
            program_pin_n_n = 1'b1;
            flags = 5'h00;
        end
        repeat (3) @(negedge i_clk);
        hst.xfer(r[24], 1'b1, `STATUS_ADDR, s);
        rd_chk(r[25], `STATUS_ADDR);
        rd_chk(r[26], r[31:27]);
    endtask : rand_step

    // Legacy write, then the serial stream MSB first when the write is taken
    task automatic legacy(input logic jt, input logic [2:0] m, input logic [31:0] w);
        logic ser;
        ser = !jt && (m == `MODE_MASTER_SERIAL || m == `MODE_SLAVE_SERIAL);
        @(negedge i_clk);
        mode = m;
        repeat (3) @(negedge i_clk);
        hst.xfer(jt, 1'b1, `LEGACY_OUT_ADDR, w);
        repeat (2) @(negedge i_clk);
        check({31'h0, busy}, {31'h0, ser}, "legacy busy");
        // Bit 31 already stands at this falling edge; one bit per cycle after it
        for (int i = 31; ser && i >= 0; i--) begin
            check({31'h0, dout}, {31'h0, w[i]}, "serial bit");
            @(negedge i_clk);
        end
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n == 40) begin
                check(32'h1, 32'h0, "busy stuck");
                print_verdict();
            end
            @(negedge i_clk);
        end
    endtask : legacy

    // Main sequence
    initial begin
        repeat (20) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_clk);
        rd_chk(1'b0, `STATUS_ADDR);
        rd_chk(1'b1, 5'h1F);
        for (int k = 0; k < 80; k++) begin
            rand_step();
        end
        legacy(1'b0, `MODE_MASTER_SERIAL, 32'hA5C3_0F81);
        legacy(1'b0, `MODE_SLAVE_SERIAL, $random(seed));
        legacy(1'b0, 3'h2, 32'hFFFF_FFFF);
        legacy(1'b1, `MODE_SLAVE_SERIAL, 32'h8000_0001);
        print_verdict();
    end
endmodule : tb_config_status_reporting
